// [rtl/port_pkg.sv]
// Purpose: Shared constants for the general-purpose I/O port block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Sleep mode codes and register offsets are local choices
package port_pkg;
   localparam int unsigned PIN_COUNT = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] DIR_OFS = 8'h00;
   localparam logic [7:0] OUT_OFS = 8'h04;
   localparam logic [7:0] SAMPLE_OFS = 8'h08;
   localparam logic [7:0] SFR_OFS = 8'h0C;
   localparam logic [7:0] SLEEP_OFS = 8'h10;
   localparam logic [7:0] INT_EN_OFS = 8'h14;
   localparam logic [7:0] ANY_EDGE_OFS = 8'h18;
   localparam logic [7:0] FLAG_OFS = 8'h1C;
   // Field positions
   localparam int unsigned PULLUP_OFF_BIT = 2;
   localparam int unsigned SLEEP_MODE_LSB = 0;
   localparam int unsigned SLEEP_MODE_W = 3;
   localparam int unsigned SLEEP_ACTIVE_BIT = 3;
   // Reset values
   localparam logic [31:0] DIR_RST = 32'h0000_0000;
   localparam logic [31:0] OUT_RST = 32'h0000_0000;
   localparam logic [31:0] INT_EN_RST = 32'h0000_0000;
   localparam logic [31:0] ANY_EDGE_RST = 32'h0000_0000;
   localparam logic PULLUP_OFF_RST = 1'b0;
   localparam logic [2:0] SLEEP_MODE_RST = 3'h0;
   // Sleep mode codes
   typedef enum logic [2:0]
   {
      MODE_IDLE = 3'h0,
      MODE_ADC_QUIET = 3'h1,
      MODE_POWER_DOWN = 3'h2,
      MODE_POWER_SAVE = 3'h3,
      MODE_STANDBY = 3'h6,
      MODE_EXT_STANDBY = 3'h7
   } sleep_mode_t;
endpackage

// [rtl/port_pin_cell.sv]
// Purpose: Combinational override logic of one port pin
// Assumes: Override enables already masked for pins without alternate function
// Notes: Pure logic; the port top registers every pad-facing result
`timescale 1ns/100ps
module port_pin_cell
(
   input wire logic pin_direction_bit_i,
   input wire logic pin_output_value_bit_i,
   input wire logic global_pullup_off_i,
   input wire logic sleep_clamp_i,
   input wire logic ext_int_enable_i,
   input wire logic pullup_override_enable_i,
   input wire logic pullup_override_value_i,
   input wire logic direction_override_enable_i,
   input wire logic direction_override_value_i,
   input wire logic level_override_enable_i,
   input wire logic level_override_value_i,
   input wire logic input_gate_override_enable_i,
   input wire logic input_gate_override_value_i,
   input wire logic pad_i,
   output logic pullup_o,
   output logic drive_en_o,
   output logic drive_level_o,
   output logic input_en_o,
   output logic digital_in_o
);
   logic plain_pullup;
   logic plain_input_en;

   always_comb
   begin
      plain_pullup = (~pin_direction_bit_i) & pin_output_value_bit_i & (~global_pullup_off_i);
      if (pullup_override_enable_i)
      begin
         pullup_o = pullup_override_value_i;
      end
      else
      begin
         pullup_o = plain_pullup;
      end
   end

   always_comb
   begin
      if (direction_override_enable_i)
      begin
         drive_en_o = direction_override_value_i;
      end
      else
      begin
         drive_en_o = pin_direction_bit_i;
      end
   end

   always_comb
   begin
      if (level_override_enable_i)
      begin
         drive_level_o = level_override_value_i;
      end
      else
      begin
         drive_level_o = pin_output_value_bit_i;
      end
   end

   always_comb
   begin
      plain_input_en = ~(sleep_clamp_i & ~ext_int_enable_i);
      if (input_gate_override_enable_i)
      begin
         input_en_o = input_gate_override_value_i;
      end
      else
      begin
         input_en_o = plain_input_en;
      end
      digital_in_o = pad_i & input_en_o;
   end
endmodule // port_pin_cell

// [rtl/port_pin_override_logic.sv]
// Purpose: One general-purpose I/O port with alternate-function overrides and sleep input clamp
// Assumes: APB slave, single clock, synchronous active-low reset, synchronous pad inputs
// Notes: Alternate input and analog path are pass-through and not registered
`timescale 1ns/100ps
module port_pin_override_logic
#(
   parameter int unsigned WIDTH = port_pkg::PIN_COUNT,
   parameter logic [port_pkg::PIN_COUNT-1:0] ALT_MASK = 8'hFF
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [port_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [port_pkg::DATA_W-1:0] pwdata_i,
   output logic [port_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic wake_i,
   input wire logic [WIDTH-1:0] pullup_override_enable_i,
   input wire logic [WIDTH-1:0] pullup_override_value_i,
   input wire logic [WIDTH-1:0] direction_override_enable_i,
   input wire logic [WIDTH-1:0] direction_override_value_i,
   input wire logic [WIDTH-1:0] level_override_enable_i,
   input wire logic [WIDTH-1:0] level_override_value_i,
   input wire logic [WIDTH-1:0] input_gate_override_enable_i,
   input wire logic [WIDTH-1:0] input_gate_override_value_i,
   input wire logic [WIDTH-1:0] pad_i,
   output logic [WIDTH-1:0] pad_o,
   output logic [WIDTH-1:0] pad_oe_o,
   output logic [WIDTH-1:0] pullup_o,
   output logic [WIDTH-1:0] alt_pin_input_o,
   input wire logic [WIDTH-1:0] alt_analog_pad_out_i,
   input wire logic [WIDTH-1:0] alt_analog_pad_oe_i,
   output logic [WIDTH-1:0] alt_analog_pad_in_o,
   output logic [WIDTH-1:0] alt_analog_pad_drive_o,
   output logic [WIDTH-1:0] alt_analog_pad_drive_oe_o,
   output logic sleep_clamp_o
);
   import port_pkg::*;

   logic [WIDTH-1:0] dir_r;
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] int_en_r;
   logic [WIDTH-1:0] any_edge_r;
   logic [WIDTH-1:0] flag_r;
   logic [WIDTH-1:0] flag_nxt;
   logic pullup_off_r;
   logic [SLEEP_MODE_W-1:0] sleep_mode_r;
   logic sleep_active_r;
   logic sleep_clamp;
   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sample_r;
   logic [WIDTH-1:0] sample_prev_r;
   logic [WIDTH-1:0] cell_pullup;
   logic [WIDTH-1:0] cell_drive_en;
   logic [WIDTH-1:0] cell_level;
   logic [WIDTH-1:0] cell_digital_in;
   logic access;
   logic wr_en;
   logic dir_wr_stb;
   logic out_wr_stb;
   logic sfr_wr_stb;
   logic sleep_wr_stb;
   logic int_en_wr_stb;
   logic any_edge_wr_stb;
   logic flag_wr_stb;
   logic mapped;
   logic [DATA_W-1:0] rd_word;

   // Deep sleep modes that gate the pad inputs
   function automatic logic is_clamp_mode(input logic [SLEEP_MODE_W-1:0] mode);
      is_clamp_mode = (mode == MODE_POWER_DOWN) || (mode == MODE_POWER_SAVE) ||
                      (mode == MODE_STANDBY) || (mode == MODE_EXT_STANDBY);
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [WIDTH-1:0] v);
      widen = '0;
      widen[WIDTH-1:0] = v;
   endfunction

   // Bus decode; one strobe per writable register (none for the read-only sample register), shared by all pins of the port
   assign access = psel_i & penable_i & pready_o;
   assign wr_en = access & pwrite_i;
   assign dir_wr_stb = wr_en & (paddr_i == DIR_OFS);
   assign out_wr_stb = wr_en & (paddr_i == OUT_OFS);
   assign sfr_wr_stb = wr_en & (paddr_i == SFR_OFS);
   assign sleep_wr_stb = wr_en & (paddr_i == SLEEP_OFS);
   assign int_en_wr_stb = wr_en & (paddr_i == INT_EN_OFS);
   assign any_edge_wr_stb = wr_en & (paddr_i == ANY_EDGE_OFS);
   assign flag_wr_stb = wr_en & (paddr_i == FLAG_OFS);

   always_comb
   begin
      mapped = 1'b1;
      rd_word = '0;
      unique case (paddr_i)
         DIR_OFS: rd_word = widen(dir_r);
         OUT_OFS: rd_word = widen(out_r);
         SAMPLE_OFS: rd_word = widen(sample_r);
         SFR_OFS: rd_word[PULLUP_OFF_BIT] = pullup_off_r;
         SLEEP_OFS:
         begin
            rd_word[SLEEP_MODE_LSB +: SLEEP_MODE_W] = sleep_mode_r;
            rd_word[SLEEP_ACTIVE_BIT] = sleep_active_r;
         end
         INT_EN_OFS: rd_word = widen(int_en_r);
         ANY_EDGE_OFS: rd_word = widen(any_edge_r);
         FLAG_OFS: rd_word = widen(flag_r);
         default: mapped = 1'b0;
      endcase
   end

   // Access phase lasts two cycles; pready rises in the second
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
      end
      else
      begin
         pready_o <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
         if (psel_i & penable_i & ~pready_o & ~pwrite_i)
         begin
            prdata_o <= rd_word;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         dir_r <= DIR_RST[WIDTH-1:0];
         out_r <= OUT_RST[WIDTH-1:0];
         int_en_r <= INT_EN_RST[WIDTH-1:0];
         any_edge_r <= ANY_EDGE_RST[WIDTH-1:0];
         pullup_off_r <= PULLUP_OFF_RST;
      end
      else
      begin
         if (dir_wr_stb)
         begin
            dir_r <= pwdata_i[WIDTH-1:0];
         end
         if (out_wr_stb)
         begin
            out_r <= pwdata_i[WIDTH-1:0];
         end
         if (int_en_wr_stb)
         begin
            int_en_r <= pwdata_i[WIDTH-1:0];
         end
         if (any_edge_wr_stb)
         begin
            any_edge_r <= pwdata_i[WIDTH-1:0];
         end
         if (sfr_wr_stb)
         begin
            pullup_off_r <= pwdata_i[PULLUP_OFF_BIT];
         end
      end
   end

   // Sleep controller: software enters, wake event leaves
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         sleep_mode_r <= SLEEP_MODE_RST;
         sleep_active_r <= 1'b0;
      end
      else if (wake_i)
      begin
         sleep_active_r <= 1'b0;
      end
      else if (sleep_wr_stb)
      begin
         sleep_mode_r <= pwdata_i[SLEEP_MODE_LSB +: SLEEP_MODE_W];
         sleep_active_r <= pwdata_i[SLEEP_ACTIVE_BIT];
      end
   end

   assign sleep_clamp = sleep_active_r & is_clamp_mode(sleep_mode_r);

   // Per-pin override cells; enables masked where a pin has no alternate function
   // Peripherals drive enables and values directly
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_pin
         port_pin_cell u_cell
         (
            .pin_direction_bit_i(dir_r[g]),
            .pin_output_value_bit_i(out_r[g]),
            .global_pullup_off_i(pullup_off_r),
            .sleep_clamp_i(sleep_clamp),
            .ext_int_enable_i(int_en_r[g]),
            .pullup_override_enable_i(pullup_override_enable_i[g] & ALT_MASK[g]),
            .pullup_override_value_i(pullup_override_value_i[g]),
            .direction_override_enable_i(direction_override_enable_i[g] & ALT_MASK[g]),
            .direction_override_value_i(direction_override_value_i[g]),
            .level_override_enable_i(level_override_enable_i[g] & ALT_MASK[g]),
            .level_override_value_i(level_override_value_i[g]),
            .input_gate_override_enable_i(input_gate_override_enable_i[g] & ALT_MASK[g]),
            .input_gate_override_value_i(input_gate_override_value_i[g]),
            .pad_i(pad_i[g]),
            .pullup_o(cell_pullup[g]),
            .drive_en_o(cell_drive_en[g]),
            .drive_level_o(cell_level[g]),
            .input_en_o(),
            .digital_in_o(cell_digital_in[g])
         );
      end
   endgenerate

   // Raw gated input for alternate users, unsynchronised
   assign alt_pin_input_o = cell_digital_in;

   // Analog path bypasses all digital buffering
   assign alt_analog_pad_in_o = pad_i;
   assign alt_analog_pad_drive_o = alt_analog_pad_out_i;
   assign alt_analog_pad_drive_oe_o = alt_analog_pad_oe_i;

   // Pad drive registers; tri-state and pull-ups off during reset
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         pad_oe_o <= '0;
         pad_o <= '0;
         pullup_o <= '0;
         sleep_clamp_o <= 1'b0;
      end
      else
      begin
         pad_oe_o <= cell_drive_en;
         pad_o <= cell_level & cell_drive_en;
         pullup_o <= cell_pullup;
         sleep_clamp_o <= sleep_clamp;
      end
   end

   // Two-stage synchroniser feeding the sample register
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         sync1_r <= '0;
         sample_r <= '0;
         sample_prev_r <= '0;
      end
      else
      begin
         sync1_r <= cell_digital_in;
         sample_r <= sync1_r;
         sample_prev_r <= sample_r;
      end
   end

   // Any-edge flags set on every change of the gated input of a pin enabled in any_edge_r; deep sleep gates it unless interrupt on; set wins over clear
   always_comb
   begin
      flag_nxt = flag_r;
      if (flag_wr_stb)
      begin
         flag_nxt = flag_r & ~pwdata_i[WIDTH-1:0];
      end
      flag_nxt = flag_nxt | (any_edge_r & (sample_r ^ sample_prev_r));
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         flag_r <= '0;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end
endmodule // port_pin_override_logic

// [sim/port_pin_override_logic_props.sv]
// Purpose: Concurrent checks on the port pins and the bus handshake
// Assumes: Pad outputs registered one edge after their cause
// Notes: Pins outside ALT_MASK ignore their override inputs
`timescale 1ns/100ps
module port_pin_override_logic_props
#(
   parameter int unsigned WIDTH = 8,
   parameter logic [port_pkg::PIN_COUNT-1:0] ALT_MASK = 8'hFF
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sleep_clamp_o,
   input wire logic [WIDTH-1:0] pad_i,
   input wire logic [WIDTH-1:0] pad_o,
   input wire logic [WIDTH-1:0] pad_oe_o,
   input wire logic [WIDTH-1:0] pullup_o,
   input wire logic [WIDTH-1:0] alt_pin_input_o,
   input wire logic [WIDTH-1:0] pullup_override_enable_i,
   input wire logic [WIDTH-1:0] pullup_override_value_i,
   input wire logic [WIDTH-1:0] direction_override_enable_i,
   input wire logic [WIDTH-1:0] direction_override_value_i,
   input wire logic [WIDTH-1:0] level_override_enable_i,
   input wire logic [WIDTH-1:0] level_override_value_i,
   input wire logic [WIDTH-1:0] input_gate_override_enable_i,
   input wire logic [WIDTH-1:0] input_gate_override_value_i,
   input wire logic [WIDTH-1:0] alt_analog_pad_out_i,
   input wire logic [WIDTH-1:0] alt_analog_pad_oe_i,
   input wire logic [WIDTH-1:0] alt_analog_pad_in_o,
   input wire logic [WIDTH-1:0] alt_analog_pad_drive_o,
   input wire logic [WIDTH-1:0] alt_analog_pad_drive_oe_o
);
   import port_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_first_access;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_awake;
      !sleep_clamp_o [*3];
   endsequence
   apb_ready_a: assert property (s_first_access |=> pready_o) else $error("late ready");
   apb_error_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   reset_off_a: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |-> pullup_o == '0 && pad_oe_o == '0)
      else $error("pad active in reset");
   pullup_ovr_a: assert property ($past(rst_n_i) |-> ((pullup_o ^ $past(pullup_override_value_i))
      & $past(pullup_override_enable_i) & ALT_MASK) == '0) else $error("pull-up override lost");
   drive_ovr_a: assert property ($past(rst_n_i) |-> ((pad_oe_o ^ $past(direction_override_value_i))
      & $past(direction_override_enable_i) & ALT_MASK) == '0) else $error("drive override lost");
   level_ovr_a: assert property ($past(rst_n_i) |-> ((pad_o ^ $past(level_override_value_i)) & pad_oe_o
      & $past(level_override_enable_i) & ALT_MASK) == '0) else $error("level override lost");
   input_ovr_a: assert property (((alt_pin_input_o ^ (pad_i & input_gate_override_value_i))
      & input_gate_override_enable_i & ALT_MASK) == '0) else $error("input override lost");
   input_open_a: assert property (s_awake |-> (($past(alt_pin_input_o) ^ $past(pad_i))
      & ~$past(input_gate_override_enable_i & ALT_MASK)) == '0) else $error("input gated awake");
   analog_path_a: assert property (alt_analog_pad_in_o == pad_i
      && alt_analog_pad_drive_o == alt_analog_pad_out_i
      && alt_analog_pad_drive_oe_o == alt_analog_pad_oe_i) else $error("analog path broken");
endmodule // port_pin_override_logic_props
bind port_pin_override_logic port_pin_override_logic_props #(.WIDTH(WIDTH), .ALT_MASK(ALT_MASK)) props_u
   (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .sleep_clamp_o, .pad_i, .pad_o, .pad_oe_o,
   .pullup_o, .alt_pin_input_o, .pullup_override_enable_i, .pullup_override_value_i, .direction_override_enable_i,
   .direction_override_value_i, .level_override_enable_i, .level_override_value_i, .input_gate_override_enable_i,
   .input_gate_override_value_i, .alt_analog_pad_out_i, .alt_analog_pad_oe_i, .alt_analog_pad_in_o,
   .alt_analog_pad_drive_o, .alt_analog_pad_drive_oe_o);

// [sim/pad_partner.sv]
// Purpose: External pad and alternate-function side model
// Assumes: The port driver wins over an external source
// Notes: Undriven unpulled pins toggle every cycle
`timescale 1ns/100ps
module pad_partner
(
   input wire logic clk_i,
   input wire logic [7:0] oe_i,
   input wire logic [7:0] lvl_i,
   input wire logic [7:0] pu_i,
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   input wire logic [7:0] alt_i,
   output logic [7:0] pad_o,
   output logic [7:0] alt_sync_o
);
   logic [7:0] float_r = 8'h5A;
   logic [7:0] sync_r = 8'h00;
   always_ff @(posedge clk_i)
      float_r <= ~float_r;
   // Raw alternate input synchronised on the peripheral side
   always_ff @(posedge clk_i)
   begin
      sync_r <= alt_i;
      alt_sync_o <= sync_r;
   end
   always_comb
      pad_o = (oe_i & lvl_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | float_r));
endmodule // pad_partner

// [sim/port_pin_override_logic_test.sv]
// Purpose: Self-checking bench of the port block
// Assumes: Two-cycle bus access, pad outputs one edge late
// Notes: Pin 7 has no alternate function here
`timescale 1ns/100ps
module port_pin_override_logic_test;
   import port_pkg::*;
   localparam logic [7:0] M = 8'h7F;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, wake_i = 1'b0;
   logic [7:0] paddr_i = 8'h00, ext_en = 8'h00, ext = 8'h00, alt_analog_pad_out_i = 8'h00, alt_analog_pad_oe_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [7:0] pullup_override_enable_i = 8'h00, pullup_override_value_i = 8'h00, direction_override_enable_i = 8'h00;
   logic [7:0] direction_override_value_i = 8'h00, level_override_enable_i = 8'h00, level_override_value_i = 8'h00;
   logic [7:0] input_gate_override_enable_i = 8'h00, input_gate_override_value_i = 8'h00;
   wire [7:0] pad_i, pad_o, pad_oe_o, pullup_o, alt_pin_input_o;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, sleep_clamp_o;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [32:0] q[$];
   logic [7:0] d, o, e, pe, pv, de, dv, le, lv, ep, eo;
   logic global_pullup_off, c;
   sleep_mode_t md [6] = '{MODE_IDLE, MODE_ADC_QUIET, MODE_POWER_DOWN, MODE_POWER_SAVE, MODE_STANDBY, MODE_EXT_STANDBY};
   port_pin_override_logic #(.ALT_MASK(M)) dut_u (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wake_i, .pullup_override_enable_i, .pullup_override_value_i,
      .direction_override_enable_i, .direction_override_value_i, .level_override_enable_i, .level_override_value_i,
      .input_gate_override_enable_i, .input_gate_override_value_i, .pad_i, .pad_o, .pad_oe_o, .pullup_o,
      .alt_pin_input_o, .alt_analog_pad_out_i, .alt_analog_pad_oe_i, .alt_analog_pad_in_o(),
      .alt_analog_pad_drive_o(), .alt_analog_pad_drive_oe_o(), .sleep_clamp_o);
   pad_partner part_u (.clk_i(sys_clk_i), .oe_i(pad_oe_o), .lvl_i(pad_o), .pu_i(pullup_o), .ext_en_i(ext_en),
      .ext_val_i(ext), .alt_i(alt_pin_input_o), .pad_o(pad_i), .alt_sync_o());
   always #4 sys_clk_i = ~sys_clk_i;
   task report_and_stop;
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [32:0] s, input logic [32:0] x);
      tests_run++;
      if (s !== x)
      begin
         $display("mismatch %s expected %h seen %h", nm, x, s);
         n_mismatch++;
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] x);
      q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   task look(input logic [7:0] xp, input logic [7:0] xo, input logic [7:0] xl);
      tick(2);
      @(negedge sys_clk_i);
      chk("pullup", pullup_o, xp);
      chk("drive_en", pad_oe_o, xo);
      chk("drive_level", pad_o, xl);
      @(posedge sys_clk_i);
   endtask
   always @(posedge sys_clk_i)
      if (psel_i === 1'b1 && penable_i === 1'b1 && pready_o === 1'b1 && pwrite_i === 1'b0 && q.size() > 0)
         chk("prdata", {pslverr_o, prdata_o}, q.pop_front());
   initial
   begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(21));
      tick(20);
      rst_n_i <= 1'b1;
      look(8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         d = 8'($urandom);
         o = 8'($urandom);
         global_pullup_off = 1'($urandom);
         {pe, pv, de, dv} = (i < 4) ? 32'h0 : $urandom;
         {le, lv} = (i < 4) ? 16'h0 : 16'($urandom);
         {pullup_override_enable_i, pullup_override_value_i, direction_override_enable_i} <= {pe, pv, de};
         {direction_override_value_i, level_override_enable_i, level_override_value_i} <= {dv, le, lv};
         alt_analog_pad_out_i <= 8'($urandom);
         alt_analog_pad_oe_i <= 8'($urandom);
         apb(1'b1, DIR_OFS, {24'h0, d});
         apb(1'b1, OUT_OFS, {24'h0, o});
         apb(1'b1, SFR_OFS, {29'h0, global_pullup_off, 2'h0});
         rd(DIR_OFS, {25'h0, d});
         ep = (pe & M & pv) | (~(pe & M) & ~d & o & {8{~global_pullup_off}});
         eo = (de & M & dv) | (~(de & M) & d);
         look(ep, eo, eo & ((le & M & lv) | (~(le & M) & o)));
      end
      {pullup_override_enable_i, direction_override_enable_i, level_override_enable_i} <= 24'h0;
      apb(1'b1, DIR_OFS, 32'h0);
      e = 8'($urandom);
      ext_en <= 8'hFF;
      ext <= e;
      tick(3);
      rd(SAMPLE_OFS, {25'h0, e});
      foreach (md[k])
      begin
         apb(1'b1, SLEEP_OFS, {28'h0, 1'b1, md[k]});
         c = md[k] inside {MODE_POWER_DOWN, MODE_POWER_SAVE, MODE_STANDBY, MODE_EXT_STANDBY};
         tick(3);
         @(negedge sys_clk_i);
         chk("clamp", sleep_clamp_o, c);
         chk("alt_input", alt_pin_input_o, c ? 8'h00 : e);
         @(posedge sys_clk_i);
         wake_i <= 1'b1;
         tick(1);
         wake_i <= 1'b0;
         tick(2);
      end
      apb(1'b1, INT_EN_OFS, 32'hFF);
      apb(1'b1, SLEEP_OFS, {28'h0, 1'b1, MODE_POWER_DOWN});
      tick(3);
      @(negedge sys_clk_i);
      chk("escape", alt_pin_input_o, e);
      @(posedge sys_clk_i);
      d = 8'($urandom);
      input_gate_override_enable_i <= 8'hFF;
      input_gate_override_value_i <= d;
      apb(1'b1, INT_EN_OFS, 32'h0);
      tick(2);
      @(negedge sys_clk_i);
      chk("gate_override", alt_pin_input_o, (e & d & M));
      @(posedge sys_clk_i);
      input_gate_override_enable_i <= 8'h00;
      ext <= 8'h01;
      apb(1'b1, ANY_EDGE_OFS, 32'h1);
      tick(4);
      apb(1'b1, FLAG_OFS, 32'hFF);
      rd(FLAG_OFS, 33'h0);
      wake_i <= 1'b1;
      tick(1);
      wake_i <= 1'b0;
      tick(6);
      rd(FLAG_OFS, 33'h1);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      rd(8'h20, {1'b1, 32'h0});
      apb(1'b1, SFR_OFS, 32'h0);
      apb(1'b1, OUT_OFS, 32'hFF);
      look(8'hFF, 8'h00, 8'h00);
      rst_n_i <= 1'b0;
      look(8'h00, 8'h00, 8'h00);
      rst_n_i <= 1'b1;
      tick(2);
      report_and_stop();
   end
endmodule // port_pin_override_logic_test
